// *** rtl/bldcfg_map.svh ***
// Register offsets, field positions, reset values and timing figures
// for the motor configuration block. Definitions only.
`ifndef BLDCFG_MAP_SVH
`define BLDCFG_MAP_SVH

// Register offsets (word index on the register port)
`define BLDCFG_ADDR_CTRL 4'h0
`define BLDCFG_ADDR_ADV 4'h1
`define BLDCFG_ADDR_LOCKQ 4'h2
`define BLDCFG_ADDR_TOL 4'h3

// Reset values and the register 0x01 write mask
`define BLDCFG_RST_CTRL 16'h0000
`define BLDCFG_RST_ADV 16'h0000
`define BLDCFG_RST_LOCKQ 16'h0000
`define BLDCFG_RST_TOL 16'h0000
`define BLDCFG_ADV_WMASK 16'h00FF

// Register 0x00 fields
`define BLDCFG_BRKPOL_BIT 9
`define BLDCFG_SYNREC_BIT 8
`define BLDCFG_RATE_HI 7
`define BLDCFG_RATE_LO 6
`define BLDCFG_SPDM_HI 5
`define BLDCFG_SPDM_LO 4
`define BLDCFG_FBSEL_HI 3
`define BLDCFG_FBSEL_LO 2
`define BLDCFG_DISACT_BIT 1
`define BLDCFG_RETRY_BIT 0

// Register 0x01 fields
`define BLDCFG_ADV_HI 7
`define BLDCFG_ADV_LO 0

// Register 0x02 fields
`define BLDCFG_LPC_HI 15
`define BLDCFG_LPC_LO 8
`define BLDCFG_MINSP_HI 7
`define BLDCFG_MINSP_LO 0

// Register 0x03 fields
`define BLDCFG_BASIC_BIT 15
`define BLDCFG_TOL_HI 14
`define BLDCFG_TOL_LO 12

// Tolerance: code 0 is a shift of 9 (1/512), code 7 a shift of 2 (1/4)
`define BLDCFG_TOL_SHIFT0 4'h9

// Timing
`define BLDCFG_CLK_NS 8
`define BLDCFG_TICK_NS 2560000
`define BLDCFG_RETRY_NS 1000
`define BLDCFG_RETRY_CYC (`BLDCFG_RETRY_NS / `BLDCFG_CLK_NS)

`endif

// *** rtl/bldcfg_pkg.sv ***
// Types shared by the motor configuration block.
// Assumes the map header supplies all numeric constants.
package bldcfg_pkg;

  typedef enum logic [1:0] {
    SPD_CLK_FREQ = 2'b00,
    SPD_CLK_PWM = 2'b01,
    SPD_REG_PWM = 2'b10,
    SPD_RESERVED = 2'b11
  } bldcfg_speed_mode_select_t;

  typedef enum logic [1:0] {
    FB_HALL_U = 2'b00,
    FB_HALL_XOR = 2'b01,
    FB_AMP = 2'b10,
    FB_TACHOMETER = 2'b11
  } bldcfg_fbsel_t;

  typedef enum logic [1:0] {
    FLT_IDLE = 2'b00,
    FLT_LATCH = 2'b01,
    FLT_WAIT = 2'b10
  } bldcfg_fault_t;

endpackage : bldcfg_pkg

// *** rtl/bldcfg_gate_ctl.sv ***
// Gate action control: fault handling, disable action and stop request.
// Assumes all inputs are synchronous to clk.
`timescale 1ns/1ps
`include "bldcfg_map.svh"

module bldcfg_gate_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic stop_in,
  input wire logic enable_active,
  input wire logic fault_in,
  input wire logic brake_pol,
  input wire logic disable_action,
  input wire logic retry_en,
  output logic gate_hiz_q,
  output logic gate_brake_q,
  output logic gate_run_q,
  output logic fault_off_q
);

  bldcfg_pkg::bldcfg_fault_t state_q, state_d;
  logic [7:0] wait_q, wait_d;
  logic stop_req;
  logic off;
  logic hiz_d, brake_d, run_d;

  assign stop_req = brake_pol ? ~stop_in : stop_in;
  assign off = (state_q != bldcfg_pkg::FLT_IDLE) || fault_in;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      bldcfg_pkg::FLT_IDLE: begin
        if (fault_in) begin
          state_d = retry_en ? bldcfg_pkg::FLT_WAIT : bldcfg_pkg::FLT_LATCH;
          wait_d = 8'h00;
        end
      end
      bldcfg_pkg::FLT_WAIT: begin
        if (fault_in) begin
          wait_d = 8'h00;
        end else if (wait_q == 8'(`BLDCFG_RETRY_CYC - 1)) begin
          state_d = bldcfg_pkg::FLT_IDLE;
        end else begin
          wait_d = wait_q + 8'h01;
        end
      end
      bldcfg_pkg::FLT_LATCH: begin
        state_d = bldcfg_pkg::FLT_LATCH; // Only reset releases a latched fault
      end
      default: begin
        state_d = bldcfg_pkg::FLT_IDLE;
      end
    endcase
  end

  // coast, brake: fault beats disable beats stop
  assign hiz_d = off || (!enable_active && !disable_action);
  assign brake_d = !off && ((!enable_active && disable_action) || (enable_active && stop_req));
  assign run_d = !off && enable_active && !stop_req;

  // Registered state and gate decision
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bldcfg_pkg::FLT_IDLE;
      wait_q <= 8'h00;
      gate_hiz_q <= 1'b1;
      gate_brake_q <= 1'b0;
      gate_run_q <= 1'b0;
      fault_off_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      gate_hiz_q <= hiz_d;
      gate_brake_q <= brake_d;
      gate_run_q <= run_d;
      fault_off_q <= off;
    end
  end

endmodule : bldcfg_gate_ctl

// *** rtl/bldcfg_period_meas.sv ***
// First-hall period measurement in clock cycles and in 2.56 ms ticks.
// Assumes hall_u is synchronous to clk; rising edge to rising edge.
`timescale 1ns/1ps
`include "bldcfg_map.svh"

module bldcfg_period_meas #(
  parameter int unsigned TICK_CYCLES = `BLDCFG_TICK_NS / `BLDCFG_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hall_u,
  output logic edge_q,
  output logic [27:0] period_cyc_q,
  output logic [8:0] period_ticks_q,
  output logic [8:0] live_ticks_q
);

  logic hall_prev_q;
  logic [27:0] cyc_q;
  logic [18:0] div_q;
  logic rise;
  logic tick;

  assign rise = hall_u && !hall_prev_q;
  // Tick divider restarts on every rising edge so ticks count whole periods
  assign tick = (div_q == 19'(TICK_CYCLES - 1));

  // Counters saturate so a stalled rotor never wraps to a short period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hall_prev_q <= 1'b0;
      cyc_q <= 28'h0000000;
      div_q <= 19'h00000;
      live_ticks_q <= 9'h000;
      period_cyc_q <= 28'h0000000;
      period_ticks_q <= 9'h000;
      edge_q <= 1'b0;
    end else begin
      hall_prev_q <= hall_u;
      edge_q <= rise;
      if (rise) begin
        period_cyc_q <= cyc_q;
        period_ticks_q <= live_ticks_q;
        cyc_q <= 28'h0000001;
        div_q <= 19'h00001;
        live_ticks_q <= 9'h000;
      end else begin
        if (cyc_q != 28'hFFFFFFF) cyc_q <= cyc_q + 28'h0000001;
        div_q <= tick ? 19'h00000 : div_q + 19'h00001;
        if (tick && live_ticks_q != 9'h1FF) live_ticks_q <= live_ticks_q + 9'h001;
      end
    end
  end

endmodule : bldcfg_period_meas

// *** rtl/bldcfg_top.sv ***
// Configuration registers 0x00-0x03 of a sensored brushless motor
// controller, with feedback selection, gate action and lock detection.
// Assumes a synchronous register port from a loader or serial front end
// and that all pin inputs are synchronous to SYS_CLK.
`timescale 1ns/1ps
`include "bldcfg_map.svh"

module bldcfg_top #(
  parameter int unsigned TICK_CYCLES = `BLDCFG_TICK_NS / `BLDCFG_CLK_NS
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RD_VALID,
  input wire logic STOP_IN,
  input wire logic ENABLE_ACTIVE,
  input wire logic FAULT_IN,
  input wire logic HALL_U,
  input wire logic HALL_V,
  input wire logic HALL_W,
  input wire logic FB_AMP_IN,
  input wire logic TACHOMETER_INPUT,
  output logic [1:0] PWM_RATE_SELECT,
  output logic [1:0] SPEED_MODE_SELECT,
  output logic SPEED_MODE_VALID,
  output logic SYNC_RECTIFY_ENABLE,
  output logic SPEED_FEEDBACK_SIGNAL,
  output logic [7:0] ADVANCE_COUNT,
  output logic HALL120_FORCE,
  output logic GATE_HIZ,
  output logic GATE_LOW_BRAKE,
  output logic GATE_RUN,
  output logic FAULT_OFF,
  output logic SPEED_LOCK
);

  // Stored registers
  logic [15:0] ctrl_q, adv_q, lockq_q, tol_q;
  logic [15:0] rdata_q;
  logic rd_valid_q;

  // Derived outputs, all registered
  logic mode_valid_q;
  logic fb_q;
  logic [7:0] adv_out_q;
  logic basic_q;

  // Lock qualification state
  logic [27:0] prev_period_q;
  logic [7:0] qual_cnt_q;
  logic lock_q;

  // Fields
  logic brake_pol;
  logic disable_action_bit;
  logic retry_en;
  logic [1:0] feedback_source_select;
  logic [1:0] speed_mode_select;
  logic [7:0] lock_period_count;
  logic [7:0] min_speed_period;
  logic [2:0] speed_tolerance_select;
  logic basic_mode;

  // Period measurement
  logic meas_edge;
  logic [27:0] period_cyc;
  logic [8:0] period_ticks;
  logic [8:0] live_ticks;

  // Decode
  logic sel_ctrl, sel_adv, sel_lockq, sel_tol;
  logic [15:0] rd_mux;
  logic fb_d;
  logic tol_ok, min_ok, stalled;
  logic [27:0] tol_limit;

  // Absolute difference of two periods
  function automatic logic [27:0] abs_diff(input logic [27:0] a, input logic [27:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff

  // Tolerance shift: code 0 divides by 512, each step doubles the window
  function automatic logic [3:0] tol_shift(input logic [2:0] code);
    tol_shift = `BLDCFG_TOL_SHIFT0 - {1'b0, code};
  endfunction : tol_shift

  // Address decode
  assign sel_ctrl = (REG_ADDR == `BLDCFG_ADDR_CTRL);
  assign sel_adv = (REG_ADDR == `BLDCFG_ADDR_ADV);
  assign sel_lockq = (REG_ADDR == `BLDCFG_ADDR_LOCKQ);
  assign sel_tol = (REG_ADDR == `BLDCFG_ADDR_TOL);

  // read returns stored values; unmapped reads give zero
  assign rd_mux = sel_ctrl ? ctrl_q :
                  sel_adv ? adv_q :
                  sel_lockq ? lockq_q :
                  sel_tol ? tol_q : 16'h0000;

  // Field extraction
  assign brake_pol = ctrl_q[`BLDCFG_BRKPOL_BIT];
  assign disable_action_bit = ctrl_q[`BLDCFG_DISACT_BIT];
  assign retry_en = ctrl_q[`BLDCFG_RETRY_BIT];
  assign feedback_source_select = ctrl_q[`BLDCFG_FBSEL_HI:`BLDCFG_FBSEL_LO];
  assign speed_mode_select = ctrl_q[`BLDCFG_SPDM_HI:`BLDCFG_SPDM_LO];
  assign lock_period_count = lockq_q[`BLDCFG_LPC_HI:`BLDCFG_LPC_LO];
  assign min_speed_period = lockq_q[`BLDCFG_MINSP_HI:`BLDCFG_MINSP_LO];
  assign speed_tolerance_select = tol_q[`BLDCFG_TOL_HI:`BLDCFG_TOL_LO];
  assign basic_mode = tol_q[`BLDCFG_BASIC_BIT];

  // hall sources, amplifier and tachometer sources
  assign fb_d = (feedback_source_select == bldcfg_pkg::FB_HALL_U) ? HALL_U :
                (feedback_source_select == bldcfg_pkg::FB_HALL_XOR) ? (HALL_U ^ HALL_V ^ HALL_W) :
                (feedback_source_select == bldcfg_pkg::FB_AMP) ? FB_AMP_IN :
                TACHOMETER_INPUT;

  // tolerance window as a fraction of the latest period
  assign tol_limit = period_cyc >> tol_shift(speed_tolerance_select);
  assign tol_ok = abs_diff(period_cyc, prev_period_q) <= tol_limit;
  // period shorter than the minimum-speed limit
  assign min_ok = period_ticks < {1'b0, min_speed_period};
  // A rotor that stops drops lock without waiting for an edge
  assign stalled = live_ticks >= {1'b0, min_speed_period};

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= `BLDCFG_RST_CTRL;
      lockq_q <= `BLDCFG_RST_LOCKQ;
      tol_q <= `BLDCFG_RST_TOL;
    end else if (REG_WR_EN) begin
      if (sel_ctrl) ctrl_q <= REG_WDATA;
      if (sel_lockq) lockq_q <= REG_WDATA;
      if (sel_tol) tol_q <= REG_WDATA;
    end
  end

  // reserved upper byte never stored, so it reads zero
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      adv_q <= `BLDCFG_RST_ADV;
    end else if (REG_WR_EN && sel_adv) begin
      adv_q <= REG_WDATA & `BLDCFG_ADV_WMASK;
    end
  end

  // Read data is registered, one cycle after the strobe
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= REG_RD_EN;
      if (REG_RD_EN) rdata_q <= rd_mux;
    end
  end

  // reserved mode flagged, advance, basic override
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mode_valid_q <= 1'b1;
      fb_q <= 1'b0;
      adv_out_q <= 8'h00;
      basic_q <= 1'b0;
    end else begin
      mode_valid_q <= (speed_mode_select != bldcfg_pkg::SPD_RESERVED);
      fb_q <= fb_d;
      adv_out_q <= basic_mode ? 8'h00 : adv_q[`BLDCFG_ADV_HI:`BLDCFG_ADV_LO];
      basic_q <= basic_mode;
    end
  end

  // lock on the qualifying period that follows the set count of qualifying periods
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      prev_period_q <= 28'h0000000;
      qual_cnt_q <= 8'h00;
      lock_q <= 1'b0;
    end else if (meas_edge) begin
      prev_period_q <= period_cyc;
      if (tol_ok && min_ok) begin
        if (qual_cnt_q >= lock_period_count) begin
          lock_q <= 1'b1;
        end else begin
          qual_cnt_q <= qual_cnt_q + 8'h01;
        end
      end else begin
        qual_cnt_q <= 8'h00;
        lock_q <= 1'b0;
      end
    end else if (stalled) begin
      qual_cnt_q <= 8'h00;
      lock_q <= 1'b0;
    end
  end

  // First-hall period in cycles and ticks
  bldcfg_period_meas #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_meas (
    .clk(SYS_CLK),
    .rst(RESET),
    .hall_u(HALL_U),
    .edge_q(meas_edge),
    .period_cyc_q(period_cyc),
    .period_ticks_q(period_ticks),
    .live_ticks_q(live_ticks)
  );

  bldcfg_gate_ctl u_gate (
    .clk(SYS_CLK),
    .rst(RESET),
    .stop_in(STOP_IN),
    .enable_active(ENABLE_ACTIVE),
    .fault_in(FAULT_IN),
    .brake_pol(brake_pol),
    .disable_action(disable_action_bit),
    .retry_en(retry_en),
    .gate_hiz_q(GATE_HIZ),
    .gate_brake_q(GATE_LOW_BRAKE),
    .gate_run_q(GATE_RUN),
    .fault_off_q(FAULT_OFF)
  );

  // rate and mode straight from the stored register
  assign PWM_RATE_SELECT = ctrl_q[`BLDCFG_RATE_HI:`BLDCFG_RATE_LO];
  assign SPEED_MODE_SELECT = speed_mode_select;
  assign SYNC_RECTIFY_ENABLE = ctrl_q[`BLDCFG_SYNREC_BIT];
  assign SPEED_MODE_VALID = mode_valid_q;
  assign SPEED_FEEDBACK_SIGNAL = fb_q;
  assign ADVANCE_COUNT = adv_out_q;
  assign HALL120_FORCE = basic_q;
  assign SPEED_LOCK = lock_q;
  assign REG_RDATA = rdata_q;
  assign REG_RD_VALID = rd_valid_q;

endmodule : bldcfg_top

// *** bench/bldcfg_props.sv ***
// Checker for the register port, gate outputs and derived config pins.
// Sees only the top module ports; bound below its endmodule.
`timescale 1ns/1ps
module bldcfg_props (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RD_VALID,
  input wire logic ENABLE_ACTIVE,
  input wire logic FAULT_IN,
  input wire logic [1:0] PWM_RATE_SELECT,
  input wire logic [1:0] SPEED_MODE_SELECT,
  input wire logic SPEED_MODE_VALID,
  input wire logic [7:0] ADVANCE_COUNT,
  input wire logic HALL120_FORCE,
  input wire logic GATE_HIZ,
  input wire logic GATE_LOW_BRAKE,
  input wire logic GATE_RUN,
  input wire logic FAULT_OFF
);
  // One clock domain, reset disables all checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // Write to the control word and a read request
  sequence s_ctrl_wr;
    REG_WR_EN && REG_ADDR == 4'h0;
  endsequence
  sequence s_rd;
    REG_RD_EN;
  endsequence

  a_rd_valid_next: assert property (s_rd |=> REG_RD_VALID)
    else $error("read valid missing after read");
  a_rd_valid_pulse: assert property (!REG_RD_EN |=> !REG_RD_VALID)
    else $error("read valid without read");
  a_unmapped_zero: assert property (REG_RD_EN && REG_ADDR > 4'h3 |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_pwm_follow: assert property (s_ctrl_wr |=> PWM_RATE_SELECT == $past(REG_WDATA[7:6]))
    else $error("pwm rate not written");
  a_mode_valid: assert property (s_ctrl_wr |=> SPEED_MODE_SELECT == $past(REG_WDATA[5:4])
    ##1 SPEED_MODE_VALID == ($past(REG_WDATA[5:4], 2) != 2'b11))
    else $error("speed mode or valid wrong");
  a_gate_onehot: assert property ($onehot({GATE_HIZ, GATE_LOW_BRAKE, GATE_RUN}))
    else $error("gate state not one-hot");
  a_fault_hiz: assert property (FAULT_IN |=> GATE_HIZ && FAULT_OFF)
    else $error("fault did not float gates");
  a_retry_hold: assert property ($fell(FAULT_IN) |-> FAULT_OFF [*8])
    else $error("fault off released early");
  a_disabled_norun: assert property (!ENABLE_ACTIVE |=> !GATE_RUN)
    else $error("gates run while disabled");
  a_basic_noadv: assert property (HALL120_FORCE && $past(HALL120_FORCE)
    |-> ADVANCE_COUNT == 8'h00)
    else $error("advance not cleared in basic mode");
endmodule : bldcfg_props

bind bldcfg_top bldcfg_props i_bldcfg_props (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_WR_EN(REG_WR_EN), .REG_RD_EN(REG_RD_EN),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REG_RD_VALID(REG_RD_VALID), .ENABLE_ACTIVE(ENABLE_ACTIVE), .FAULT_IN(FAULT_IN),
  .PWM_RATE_SELECT(PWM_RATE_SELECT), .SPEED_MODE_SELECT(SPEED_MODE_SELECT),
  .SPEED_MODE_VALID(SPEED_MODE_VALID), .ADVANCE_COUNT(ADVANCE_COUNT),
  .HALL120_FORCE(HALL120_FORCE), .GATE_HIZ(GATE_HIZ), .GATE_LOW_BRAKE(GATE_LOW_BRAKE),
  .GATE_RUN(GATE_RUN), .FAULT_OFF(FAULT_OFF));

// *** bench/test_bldcfg_top.sv ***
// Self-checking bench for the motor configuration registers.
// Drives every pin itself; tick count cut to 16 cycles for lock runs.
`timescale 1ns/1ps
module test_bldcfg_top;
  localparam int TICK = 16;
  logic sys_clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic stop_in = 1'b0, en = 1'b1, fault = 1'b0;
  logic hu = 1'b0, hv = 1'b0, hw = 1'b0, amp = 1'b0, tacho = 1'b0;
  logic [15:0] rdata, got;
  logic [1:0] pwm, mode;
  logic [7:0] adv;
  logic rd_valid, mode_ok, sync_rect, fb, force120, hiz, brk, run, foff, lock;
  logic [31:0] seed = 32'h0BAC23CB;
  logic [15:0] model [0:3];
  int error_cnt = 0;
  int cmp_count = 0;
  int i, j;

  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  bldcfg_top #(.TICK_CYCLES(TICK)) i_bldcfg_top (
    .SYS_CLK(sys_clk), .RESET(reset), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RD_VALID(rd_valid),
    .STOP_IN(stop_in), .ENABLE_ACTIVE(en), .FAULT_IN(fault), .HALL_U(hu),
    .HALL_V(hv), .HALL_W(hw), .FB_AMP_IN(amp), .TACHOMETER_INPUT(tacho),
    .PWM_RATE_SELECT(pwm), .SPEED_MODE_SELECT(mode), .SPEED_MODE_VALID(mode_ok),
    .SYNC_RECTIFY_ENABLE(sync_rect), .SPEED_FEEDBACK_SIGNAL(fb), .ADVANCE_COUNT(adv),
    .HALL120_FORCE(force120), .GATE_HIZ(hiz), .GATE_LOW_BRAKE(brk), .GATE_RUN(run),
    .FAULT_OFF(foff), .SPEED_LOCK(lock));

  // Fixed-seed shift register for stimulus words
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected feedback bit for a source code
  function automatic logic fb_exp(input int c);
    case (c)
      0: return hu;
      1: return hu ^ hv ^ hw;
      2: return amp;
      default: return tacho;
    endcase
  endfunction : fb_exp

  // Expected {hiz, brake, run}: v = {polarity, disable action, enable, stop}
  function automatic logic [15:0] gate_exp(input logic [3:0] v);
    if (!v[1]) return v[2] ? 16'h0002 : 16'h0004;
    return (v[0] ^ v[3]) ? 16'h0002 : 16'h0001;
  endfunction : gate_exp

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Write strobe for one cycle; model drops reserved upper advance bits
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    if (a == 4'h1) model[1] = d & 16'h00FF;
    else if (a < 4'h4) model[a[1:0]] = d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk({15'h0000, rd_valid}, 16'h0001);
    d = rdata;
  endtask : rd

  // First-hall periods of 40 cycles
  task automatic hall(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      hu <= 1'b1;
      repeat (20) @(posedge sys_clk);
      hu <= 1'b0;
      repeat (19) @(posedge sys_clk);
    end
    cyc(3);
  endtask : hall

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    for (i = 0; i < 4; i++) model[i] = 16'h0000;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    // reset words, random round trips, unmapped place
    for (j = 0; j < 3; j++) begin
      for (i = 0; i < 5; i++) begin
        rd(i[3:0], got);
        chk(got, i < 4 ? model[i] : 16'h0000);
      end
      for (i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        wr(i[3:0], seed[15:0]);
      end
      wr(4'hC, 16'hFFFF);
    end
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {7'h00, i[0], i[1:0], i[1:0], 4'h0});
      cyc(2);
      chk({14'h0000, pwm}, {14'h0000, i[1:0]});
      chk({15'h0000, sync_rect}, {15'h0000, i[0]});
      chk({14'h0000, mode}, {14'h0000, i[1:0]});
      chk({15'h0000, mode_ok}, {15'h0000, i != 3});
    end
    // each feedback source against random pins
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {12'h000, i[1:0], 2'b00});
      for (j = 0; j < 6; j++) begin
        seed = lfsr(seed);
        @(posedge sys_clk);
        {hu, hv, hw, amp, tacho} <= seed[4:0];
        cyc(2);
        chk({15'h0000, fb}, {15'h0000, fb_exp(i)});
      end
    end
    // polarity, disable action, enable and stop combinations
    for (i = 0; i < 16; i++) begin
      wr(4'h0, {6'h00, i[3], 7'h00, i[2], 1'b1});
      @(posedge sys_clk);
      en <= i[1];
      stop_in <= i[0];
      cyc(3);
      chk({13'h0000, hiz, brk, run}, gate_exp(i[3:0]));
    end
    // automatic retry, then latched off until reset
    wr(4'h0, 16'h0001);
    @(posedge sys_clk);
    en <= 1'b1;
    stop_in <= 1'b0;
    fault <= 1'b1;
    cyc(4);
    chk({13'h0000, hiz, brk, run}, 16'h0004);
    @(posedge sys_clk);
    fault <= 1'b0;
    cyc(100);
    chk({15'h0000, foff}, 16'h0001);
    cyc(40);
    chk({13'h0000, hiz, brk, run}, 16'h0001);
    wr(4'h0, 16'h0000);
    @(posedge sys_clk);
    fault <= 1'b1;
    @(posedge sys_clk);
    fault <= 1'b0;
    cyc(300);
    chk({15'h0000, foff}, 16'h0001);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 4; i++) model[i] = 16'h0000;
    rd(4'h0, got);
    chk(got, model[0]);
    chk({13'h0000, hiz, brk, run}, 16'h0001);
    // advance passes through unless basic mode
    seed = lfsr(seed);
    wr(4'h1, seed[15:0]);
    wr(4'h3, 16'h7000);
    cyc(2);
    chk({8'h00, adv}, model[1]);
    wr(4'h3, 16'hF000);
    cyc(2);
    chk({15'h0000, force120}, 16'h0001);
    chk({8'h00, adv}, 16'h0000);
    // lock on the third qualifying period (count set to two), lost when too slow
    wr(4'h3, 16'h7000);
    wr(4'h2, 16'h0205);
    hall(1);
    chk({15'h0000, lock}, 16'h0000);
    hall(8);
    chk({15'h0000, lock}, 16'h0001);
    wr(4'h2, 16'h0201);
    hall(2);
    chk({15'h0000, lock}, 16'h0000);
    test_done();
  end
endmodule : test_bldcfg_top
